// File: fbdiv_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FBDIV_CTRL_MAP_SVH
`define FBDIV_CTRL_MAP_SVH

// Byte offsets on the register bus
`define OFS_LOOP_CFG 8'h00
`define OFS_RATIO 8'h04
`define OFS_INT_PART 8'h08
`define OFS_SHAPER 8'h0C
`define OFS_STATUS 8'h10

// Field positions inside the loop configuration word
`define POS_ORDER_HI 22
`define POS_ORDER_LO 21
`define POS_TRIM_HI 20
`define POS_TRIM_LO 16
`define POS_FORWARD 15
`define POS_FB_RESET 14
`define POS_DRV_RESET 13
`define POS_FORCE 12
`define POS_BACKWARD 11
`define POS_RATIONAL 10
`define POS_DENOM_HI 9

// Reset values
`define RST_LOOP_CFG 23'h000000
`define RST_RATIO 28'h0000000
`define RST_INT_PART 8'h00
`define RST_SHAPER 3'h0

// Pump current step in nanoamps (3.125 uA)
`define PUMP_STEP_NA 17'h00C35

// Timing
`define CLK_PERIOD_NS 10
`define SYNC_HOLD_NS 100
`define SYNC_HOLD_CYC ((`SYNC_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FB_STEP_DIV 4

`endif

// File: fbdiv_ctrl_pkg.sv
// Types shared by the feedback divider control block
package fbdiv_ctrl_pkg;
   typedef enum logic [2:0] {
      SYNC_IDLE = 3'b001,
      SYNC_HOLD = 3'b010,
      SYNC_FIRE = 3'b100
   } sync_state_t;

   typedef logic [1:0] axi_resp_t;
   localparam axi_resp_t RESP_OKAY = 2'h0;
   localparam axi_resp_t RESP_SLVERR = 2'h2;
endpackage

// File: ratio_accum.sv
// Fraction accumulator that turns the programmed ratio into per-step divide values
`timescale 1ns/10ps
`default_nettype none
module ratio_accum
   import fbdiv_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic step,
   input wire logic rational,
   input wire logic [2:0] shaper_order,
   input wire logic [1:0] interp_order,
   input wire logic [27:0] fraction,
   input wire logic [15:0] modulus,
   input wire logic [7:0] int_part,
   output logic [8:0] divide_value,
   output logic [2:0] phase_sel
);
   // Bits of the fraction kept at each interpolation order
   function automatic logic [27:0] keep_mask(input logic [1:0] ord);
      unique case (ord)
         2'h0: keep_mask = 28'hFFFFFFF;
         2'h1: keep_mask = 28'hFFFFFFF;
         2'h2: keep_mask = 28'hFFFFFFE;
         2'h3: keep_mask = 28'hFFFFFFC;
      endcase
   endfunction

   // Top fraction bits that phase interpolation covers exactly
   function automatic logic [2:0] phase_mask(input logic [1:0] ord);
      unique case (ord)
         2'h0: phase_mask = 3'h7;
         2'h1: phase_mask = 3'h6;
         2'h2: phase_mask = 3'h4;
         2'h3: phase_mask = 3'h0;
      endcase
   endfunction

   logic [27:0] acc_ff;
   logic [15:0] racc_ff;
   logic [27:0] eff;
   logic [27:0] addend;
   logic [28:0] sum;
   logic [16:0] rsum;
   logic use_ratio;
   logic carry;

   always_comb begin
      eff = fraction & keep_mask(interp_order);
      // shaper off, only the phase-exact part accumulates
      addend = (shaper_order != 3'h0) ? eff : (eff & {phase_mask(interp_order), 25'h0000000});
      sum = {1'b0, acc_ff} + {1'b0, addend};
      // zero modulus falls back to fixed point
      use_ratio = rational && (modulus != 16'h0000);
      rsum = {1'b0, racc_ff} + {1'b0, fraction[24:9]};
      carry = use_ratio ? (rsum >= {1'b0, modulus}) : sum[28];
   end

   // accumulators held cleared while the divider is reset
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         acc_ff <= 28'h0000000;
         racc_ff <= 16'h0000;
      end else if (step) begin
         acc_ff <= use_ratio ? 28'h0000000 : sum[27:0];
         // exact integer ratio by modulo accumulation
         racc_ff <= (use_ratio && carry) ? 16'(rsum - {1'b0, modulus}) : rsum[15:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         divide_value <= 9'h000;
         phase_sel <= 3'h0;
      end else if (step) begin
         divide_value <= {1'b0, int_part} + {8'h00, carry};
         // phase count follows the order field
         phase_sel <= use_ratio ? 3'h0 : (sum[27:25] & phase_mask(interp_order));
      end
   end
endmodule
`default_nettype wire

// File: fbdiv_ctrl.sv
// Feedback divider control for the second loop with an AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fbdiv_ctrl_map.svh"
module fbdiv_ctrl
   import fbdiv_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [8:0] divide_value,
   output logic [2:0] phase_select,
   output logic loop_b_phase_forward,
   output logic loop_b_phase_backward,
   output logic [16:0] pump_current_na,
   output logic feedback_divider_reset,
   output logic second_pair_driver_reset,
   output logic sync_pulse_loop_a,
   output logic sync_pulse_loop_b
);
   // Merge a bus write into an old word, lane by lane
   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] st);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // current = step times (code + 1)
   function automatic logic [16:0] pump_na(input logic [4:0] code);
      return 17'(`PUMP_STEP_NA * ({12'h000, code} + 17'h00001));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic [22:0] cfg_ff;
   logic [27:0] ratio_ff;
   logic [7:0] int_ff;
   logic [2:0] shaper_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_go;
   logic wr_cfg;
   logic wr_hit;
   logic [22:0] nxt_cfg;
   logic [31:0] rd_word;
   logic rd_hit;
   logic fwd_ff;
   logic bwd_ff;
   logic force_ff;
   logic [2:0] offset_ff;
   logic [2:0] core_phase;
   logic [8:0] core_div;
   logic [15:0] modulus;
   logic [1:0] step_cnt_ff;
   logic step_ff;
   sync_state_t sync_ff;
   logic [7:0] hold_cnt_ff;
   logic [16:0] pump_ff;
   logic [2:0] phase_ff;
   logic [8:0] div_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Both address and data must be present; simpler than buffering one of them
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign wr_cfg = wr_go && (s_axi_awaddr == `OFS_LOOP_CFG);
   assign wr_hit = (s_axi_awaddr == `OFS_LOOP_CFG) || (s_axi_awaddr == `OFS_RATIO) ||
                   (s_axi_awaddr == `OFS_INT_PART) || (s_axi_awaddr == `OFS_SHAPER);
   assign nxt_cfg = 23'(apply_strb({9'h000, cfg_ff}, s_axi_wdata, s_axi_wstrb));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff <= `RST_LOOP_CFG;
         ratio_ff <= `RST_RATIO;
         int_ff <= `RST_INT_PART;
         shaper_ff <= `RST_SHAPER;
      end else if (wr_go) begin
         unique case (s_axi_awaddr)
            `OFS_LOOP_CFG: cfg_ff <= nxt_cfg;
            `OFS_RATIO: ratio_ff <= 28'(apply_strb({4'h0, ratio_ff}, s_axi_wdata, s_axi_wstrb));
            `OFS_INT_PART: int_ff <= 8'(apply_strb({24'h000000, int_ff}, s_axi_wdata, s_axi_wstrb));
            `OFS_SHAPER: shaper_ff <= 3'(apply_strb({29'h0, shaper_ff}, s_axi_wdata, s_axi_wstrb));
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   ////////////////////////////////////////////////////////////////////////////////
   assign s_axi_arready = !rvalid_ff;

   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         `OFS_LOOP_CFG: rd_word = {9'h000, cfg_ff};
         `OFS_RATIO: rd_word = {4'h0, ratio_ff};
         `OFS_INT_PART: rd_word = {24'h000000, int_ff};
         `OFS_SHAPER: rd_word = {29'h0, shaper_ff};
         `OFS_STATUS: rd_word = {16'h0000, (sync_ff != SYNC_IDLE), offset_ff, phase_ff, div_ff};
         default: begin
            rd_word = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_word;
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // new value against old value gives one pulse per rising write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fwd_ff <= 1'b0;
         bwd_ff <= 1'b0;
         force_ff <= 1'b0;
      end else begin
         fwd_ff <= wr_cfg && nxt_cfg[`POS_FORWARD] && !cfg_ff[`POS_FORWARD];
         bwd_ff <= wr_cfg && nxt_cfg[`POS_BACKWARD] && !cfg_ff[`POS_BACKWARD];
         force_ff <= wr_cfg && nxt_cfg[`POS_FORCE] && !cfg_ff[`POS_FORCE];
      end
   end

   // Phase offset in eighths, applied on top of the interpolated phase at any order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offset_ff <= 3'h0;
      end else if (fwd_ff && !bwd_ff) begin
         offset_ff <= offset_ff + 3'h1;
      end else if (bwd_ff && !fwd_ff) begin
         offset_ff <= offset_ff - 3'h1;
      end
   end

   assign loop_b_phase_forward = fwd_ff;
   assign loop_b_phase_backward = bwd_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Feedback step enable; divider stands in for the reference rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_cnt_ff <= 2'h0;
         step_ff <= 1'b0;
      end else begin
         step_cnt_ff <= (step_cnt_ff == 2'(`FB_STEP_DIV - 1)) ? 2'h0 : step_cnt_ff + 2'h1;
         step_ff <= (step_cnt_ff == 2'(`FB_STEP_DIV - 1));
      end
   end

   // low six modulus bits borrowed from the ratio field
   assign modulus = {cfg_ff[`POS_DENOM_HI:0], ratio_ff[5:0]};

   ratio_accum u_accum (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(cfg_ff[`POS_FB_RESET]),
      .step(step_ff),
      .rational(cfg_ff[`POS_RATIONAL]),
      .shaper_order(shaper_ff),
      .interp_order(cfg_ff[`POS_ORDER_HI:`POS_ORDER_LO]),
      .fraction(ratio_ff),
      .modulus(modulus),
      .int_part(int_ff),
      .divide_value(core_div),
      .phase_sel(core_phase)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_ff <= 3'h0;
         div_ff <= 9'h000;
         pump_ff <= pump_na(5'h00);
      end else begin
         phase_ff <= core_phase + offset_ff;
         div_ff <= core_div;
         pump_ff <= pump_na(cfg_ff[`POS_TRIM_HI:`POS_TRIM_LO]);
      end
   end

   assign phase_select = phase_ff;
   assign divide_value = div_ff;
   assign pump_current_na = pump_ff;
   // divider held in reset while the bit stands
   assign feedback_divider_reset = cfg_ff[`POS_FB_RESET];
   // second output pair reset follows its bit
   assign second_pair_driver_reset = cfg_ff[`POS_DRV_RESET];

   ////////////////////////////////////////////////////////////////////////////////
   // hold, then one sync pulse to both loops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_ff <= SYNC_IDLE;
         hold_cnt_ff <= 8'h00;
      end else begin
         unique case (sync_ff)
            SYNC_IDLE: begin
               hold_cnt_ff <= 8'h00;
               if (force_ff) begin
                  sync_ff <= SYNC_HOLD;
               end
            end
            SYNC_HOLD: begin
               hold_cnt_ff <= hold_cnt_ff + 8'h01;
               if (hold_cnt_ff == 8'(`SYNC_HOLD_CYC - 1)) begin
                  sync_ff <= SYNC_FIRE;
               end
            end
            SYNC_FIRE: sync_ff <= SYNC_IDLE;
            default: sync_ff <= SYNC_IDLE;
         endcase
      end
   end

   assign sync_pulse_loop_a = (sync_ff == SYNC_FIRE);
   assign sync_pulse_loop_b = (sync_ff == SYNC_FIRE);

   ////////////////////////////////////////////////////////////////////////////////
   AST_FWD_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cfg && s_axi_wstrb[1] && s_axi_wdata[`POS_FORWARD] && !cfg_ff[`POS_FORWARD]
      |=> loop_b_phase_forward ##1 !loop_b_phase_forward)
      else $error("forward edge did not give one pulse");

   AST_BWD_OFFSET: assert property (@(posedge aclk) disable iff (!aresetn)
      loop_b_phase_backward && !loop_b_phase_forward |=> offset_ff == $past(offset_ff) - 3'h1)
      else $error("backward pulse did not retard offset");

   AST_NO_REPEAT: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_ff[`POS_FORWARD] && $past(cfg_ff[`POS_FORWARD]) |-> !loop_b_phase_forward)
      else $error("forward held high shifted again");

   AST_PUMP: assert property (@(posedge aclk) disable iff (!aresetn)
      $stable(cfg_ff[`POS_TRIM_HI:`POS_TRIM_LO])
      |=> pump_current_na == pump_na($past(cfg_ff[`POS_TRIM_HI:`POS_TRIM_LO], 2)))
      else $error("pump current mismatch");

   AST_FB_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_ff[`POS_FB_RESET] |=> core_phase == 3'h0 && core_div == 9'h000)
      else $error("divider not held in reset");

   // Checked the cycle after a step, so a phase left over from an older order cannot trip it
   AST_ORDER_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_ff[`POS_ORDER_HI:`POS_ORDER_LO] == 2'h2 && !cfg_ff[`POS_RATIONAL] && step_ff
      |=> core_phase[1:0] == 2'h0)
      else $error("two-phase order produced finer phase");

   AST_RATIO_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_ff[`POS_RATIONAL] && modulus != 16'h0000 && !cfg_ff[`POS_FB_RESET] && step_ff
      |=> core_phase == 3'h0 && core_div >= {1'b0, $past(int_ff)}
          && core_div <= {1'b0, $past(int_ff)} + 9'h001)
      else $error("rational divide out of range");

   AST_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
      force_ff && sync_ff == SYNC_IDLE |-> ##11 sync_pulse_loop_a && sync_pulse_loop_b)
      else $error("sync pulse not issued after hold");

   AST_SYNC_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
      sync_pulse_loop_a |=> !sync_pulse_loop_a && !sync_pulse_loop_b)
      else $error("sync pulse lasted more than one cycle");

   // Register-driven levels follow the bits written over the bus
   AST_DRV_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cfg && s_axi_wstrb[1]
      |=> second_pair_driver_reset == $past(s_axi_wdata[`POS_DRV_RESET]))
      else $error("driver reset level differs from written bit");

   AST_FB_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cfg && s_axi_wstrb[1]
      |=> feedback_divider_reset == $past(s_axi_wdata[`POS_FB_RESET]))
      else $error("divider reset level differs from written bit");

   // Interpolation off: the phase never leaves zero
   AST_ORDER_THREE: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_ff[`POS_ORDER_HI:`POS_ORDER_LO] == 2'h3 && step_ff |=> core_phase == 3'h0)
      else $error("phase moved with interpolation off");

   // Shaper off and no interpolation: no fraction may reach the divide value
   AST_NO_MOD: assert property (@(posedge aclk) disable iff (!aresetn)
      shaper_ff == 3'h0 && cfg_ff[`POS_ORDER_HI:`POS_ORDER_LO] == 2'h3
      && !cfg_ff[`POS_RATIONAL] && !cfg_ff[`POS_FB_RESET] && step_ff
      |=> core_div == {1'b0, $past(int_ff)})
      else $error("divide modulated with shaper off");

   // Offset moves only on a lone forward or backward pulse
   AST_OFFSET_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      loop_b_phase_forward == loop_b_phase_backward |=> $stable(offset_ff))
      else $error("phase offset moved without a lone shift pulse");

   COV_FORWARD: cover property (@(posedge aclk) disable iff (!aresetn) loop_b_phase_forward);
   COV_SYNC: cover property (@(posedge aclk) disable iff (!aresetn) sync_pulse_loop_b);
   COV_BACKWARD: cover property (@(posedge aclk) disable iff (!aresetn) loop_b_phase_backward);
   COV_RATIONAL: cover property (@(posedge aclk) disable iff (!aresetn)
      step_ff && cfg_ff[`POS_RATIONAL] && modulus != 16'h0000);
   COV_CARRY: cover property (@(posedge aclk) disable iff (!aresetn)
      step_ff && !cfg_ff[`POS_FB_RESET] ##1 core_div != {1'b0, int_ff});
endmodule
`default_nettype wire

// File: fbdiv_ctrl_tb.sv
// Self-checking testbench for the feedback divider control block
`timescale 1ns/10ps
`default_nettype none
module fbdiv_ctrl_tb
   import fbdiv_ctrl_pkg::*;
;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rd_note_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [8:0] divide_value;
   logic [2:0] phase_select;
   logic [16:0] pump_current_na;
   logic loop_b_phase_forward, loop_b_phase_backward, feedback_divider_reset;
   logic second_pair_driver_reset, sync_pulse_loop_a, sync_pulse_loop_b;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h0001_1ABD;
   logic [31:0] r;
   logic [4:0] t;
   rd_note_t rn;
   rd_note_t rq[$];
   logic [1:0] bq[$];
   logic [3:0] pq[$];

   fbdiv_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .divide_value, .phase_select,
      .loop_b_phase_forward, .loop_b_phase_backward, .pump_current_na,
      .feedback_divider_reset, .second_pair_driver_reset, .sync_pulse_loop_a,
      .sync_pulse_loop_b);

   initial begin
      forever #5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Master raises address and data together and holds them until taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      int n;
      n = 0;
      bq.push_back(rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin @(posedge aclk); n++; end while (s_axi_awready !== 1'b1 && n < 100);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 200);
      if (n >= 200) chk(32'h0000_0001, 32'h0000_0000, "write hang");
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic [1:0] rs);
      int n;
      n = 0;
      rq.push_back('{d: d, m: m, r: rs});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 200);
      if (n >= 200) chk(32'h0000_0001, 32'h0000_0000, "read hang");
   endtask

   // Program a ratio, pulse the divider reset, then average divide_value over 128 cycles
   task automatic run_case(input logic [31:0] cfg, input logic [31:0] ratio,
      input logic [2:0] sh, input int extra, input int nph);
      logic [7:0] ip;
      logic [31:0] sum;
      logic [7:0] seen;
      r = xs();
      ip = r[7:0] | 8'h10;
      axw(8'h0C, {29'h0, sh}, RESP_OKAY);
      axw(8'h04, ratio, RESP_OKAY);
      axw(8'h08, {24'h0, ip}, RESP_OKAY);
      axw(8'h00, cfg | 32'h0000_4000, RESP_OKAY); // set divider reset
      repeat (3) @(posedge aclk);
      chk({31'h0, feedback_divider_reset}, 32'h0000_0001, "divider reset level"); // level
      chk({23'h0, divide_value}, 32'h0000_0000, "divide held in reset"); // held at zero
      axw(8'h00, cfg, RESP_OKAY); // clear divider reset
      repeat (40) @(posedge aclk);
      sum = 32'h0000_0000;
      seen = 8'h00;
      repeat (128) begin
         @(posedge aclk);
         sum = sum + {23'h0, divide_value};
         seen[phase_select] = 1'b1;
      end
      chk(sum, 128 * ip + extra, "divide average");
      chk($countones(seen), nph, "phase count");
      $display("test ratio cfg %h ratio %h done", cfg, ratio);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Result watcher: each answer or pulse consumes the oldest note
   always @(posedge aclk) begin
      if (aresetn && s_axi_bvalid && s_axi_bready) begin
         if (bq.size() == 0) chk(32'h0000_0001, 32'h0000_0000, "stray write response");
         else chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, "bresp");
      end
      if (aresetn && s_axi_rvalid && s_axi_rready) begin
         if (rq.size() == 0) begin
            chk(32'h0000_0001, 32'h0000_0000, "stray read response");
         end else begin
            rn = rq.pop_front();
            chk(s_axi_rdata & rn.m, rn.d, "rdata");
            chk({30'h0, s_axi_rresp}, {30'h0, rn.r}, "rresp");
         end
      end
      if (aresetn && (loop_b_phase_forward | loop_b_phase_backward | sync_pulse_loop_a
         | sync_pulse_loop_b)) begin
         if (pq.size() == 0) chk(32'h0000_0001, 32'h0000_0000, "stray pulse");
         else chk({28'h0, loop_b_phase_forward, loop_b_phase_backward, sync_pulse_loop_a,
            sync_pulse_loop_b}, {28'h0, pq.pop_front()}, "pulse");
      end
   end

   // Whole run needs well under 8000 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         chk(32'h0000_0001, 32'h0000_0000, "timeout");
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({15'h0, pump_current_na}, 32'h0000_0C35, "pump after reset"); // minimum
      axw(8'h08, 32'hFFFF_FFA5, RESP_OKAY);
      axr(8'h08, 32'h0000_00A5, 32'hFFFF_FFFF, RESP_OKAY);
      axr(8'h14, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
      axw(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
      axr(8'h08, 32'h0000_00A5, 32'hFFFF_FFFF, RESP_OKAY);
      r = xs();
      axw(8'h04, r, RESP_OKAY);
      axr(8'h04, {4'h0, r[27:0]}, 32'hFFFF_FFFF, RESP_OKAY);
      $display("test register access done");
      for (int k = 0; k < 6; k++) begin
         r = xs();
         t = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : r[4:0];
         axw(8'h00, {11'h0, t, 16'h0}, RESP_OKAY);
         repeat (2) @(posedge aclk);
         chk({15'h0, pump_current_na}, 32'h0000_0C35 * ({27'h0, t} + 1), "pump"); // trim
         axr(8'h00, {11'h0, t, 16'h0}, 32'h007F_FFFF, RESP_OKAY); // readback
      end
      $display("test pump trim done");
      axw(8'h00, 32'h0000_2000, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, second_pair_driver_reset}, 32'h0000_0001, "driver reset set"); // set
      axw(8'h00, 32'h0000_0000, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, second_pair_driver_reset}, 32'h0000_0000, "driver reset clear"); // clear
      $display("test driver reset done");
      run_case(32'h0000_0000, 32'h0200_0000, 3'h0, 16, 8); // eight phases
      run_case(32'h0020_0000, 32'h0400_0000, 3'h0, 32, 4); // four phases
      run_case(32'h0040_0000, 32'h0800_0000, 3'h0, 64, 2); // two phases
      run_case(32'h0060_0000, 32'h0800_0001, 3'h0, 0, 1); // no modulation
      run_case(32'h0060_0000, 32'h0800_0000, 3'h1, 64, 1); // modulated
      run_case(32'h0060_0400, 32'h0000_0204, 3'h0, 32, 1); // rational
      run_case(32'h0060_0401, 32'h0000_2000, 3'h0, 32, 1); // high modulus
      axw(8'h00, 32'h0000_0000, RESP_OKAY);
      pq.push_back(4'b1000);
      axw(8'h00, 32'h0000_8000, RESP_OKAY); // rising forward
      axw(8'h00, 32'h0001_8000, RESP_OKAY); // held high
      repeat (5) @(posedge aclk);
      axr(8'h10, 32'h0000_1000, 32'h0000_7000, RESP_OKAY); // offset one eighth
      axw(8'h00, 32'h0000_0000, RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         pq.push_back(4'b0100);
         axw(8'h00, 32'h0000_0800, RESP_OKAY); // rising backward
         axw(8'h00, 32'h0000_0000, RESP_OKAY);
         repeat (5) @(posedge aclk);
         axr(8'h10, (k == 0) ? 32'h0000_0000 : 32'h0000_7000, 32'h0000_7000, RESP_OKAY);
      end
      $display("test phase shift done");
      pq.push_back(4'b0011);
      axw(8'h00, 32'h0000_1000, RESP_OKAY); // force sync
      axw(8'h00, 32'h0001_1000, RESP_OKAY); // held high
      repeat (20) @(posedge aclk);
      chk(pq.size(), 32'h0000_0000, "sync pulses"); // one cycle both loops
      axw(8'h00, 32'h0000_0000, RESP_OKAY);
      $display("test force sync done");
      repeat (30) @(posedge aclk);
      chk(rq.size() + bq.size() + pq.size(), 32'h0000_0000, "missing results");
      complete_run();
   end
endmodule
`default_nettype wire
